// ### ucs_uart_ctrl.sv
// ucs_uart_ctrl: config, data and status bits of an async serial port run by 16-bit host words.
// assumes a mode-0 host port (sclk idle low), pins arriving asynchronously to core_clk.
//
// Operation
// - config write loads baud select, resets zero
// - config read returns stored baud select
// - peer permit reads inverted cts pin
// - data write loads tx bits, top dropped short
// - data read gives rx bits, top zero short
// - fifo_disable_n low enables eight-deep fifo
// - infrared_timing_sel selects pulse bit timing, transmit only
// - short and extra bits set character length
// - extra bit sent as written when enabled
// - extra bit received, stored, else zero
// - irq on extra mask and extra bit
// - irq on avail mask and avail flag
// - irq on error mask and error flag
// - data read or write pops one entry after sixteenth falling edge
// - config read returns the three masks
// - config read returns short and extra enable
// - send_request drives rts inverted, reset clear
// - sixteen bit words, command in first two
// - short word discarded, action on deselect
// - irq active low open drain, independent of select
`timescale 1ns/1ps
module ucs_uart_ctrl #(
  parameter int FIFO_DEPTH = ucs_pkg::FIFO_DEPTH,
  parameter int BAUD_BASE = ucs_pkg::BAUD_BASE_CYC
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // host serial port
  input wire logic host_sclk,
  input wire logic host_cs_n,
  input wire logic host_din,
  output wire logic host_dout,
  output logic host_dout_oe_n,
  // async serial line and handshake
  input wire logic uart_rx,
  input wire logic cts_n,
  output logic uart_tx,
  output logic rts_n,
  // open-drain interrupt
  output logic irq_o,
  output logic irq_oe_n
);
  import ucs_pkg::*;

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  // bit period in core cycles for a given divisor select
  function automatic logic [TIMER_W-1:0] bit_period(input logic [BAUD_W-1:0] sel);
    bit_period = TIMER_W'(BAUD_BASE * (int'(sel) + 1));
  endfunction

  // ****************************************************
  // host port, sclk domain
  // ****************************************************
  logic [4:0] bit_cnt;
  logic [WORD_BITS-1:0] shift_in;
  logic word_fired;
  logic rd_cfg_sel;
  logic out_bit;
  logic [WORD_BITS-1:0] cfg_snap;
  logic [WORD_BITS-1:0] dat_snap;
  logic [WORD_BITS-1:0] out_word;

  // deselect clears the count at once; sclk does not run between frames
  always_ff @(posedge host_sclk or posedge host_cs_n or posedge rst) begin
    if (rst) begin
      bit_cnt <= 5'h00;
    end else if (host_cs_n) begin
      bit_cnt <= 5'h00;
    end else if (bit_cnt != CNT_FULL) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // din taken on rising edges, only the first sixteen
  always_ff @(posedge host_sclk) begin
    if (bit_cnt != CNT_FULL) begin
      shift_in <= {shift_in[WORD_BITS-2:0], host_din};
    end
  end

  // snapshots are frozen by the core while selected, so sampling them here is quiet
  always_comb begin
    out_word = ((bit_cnt == CNT_CMD) ? (shift_in[1:0] == CMD_RD_CFG) : rd_cfg_sel) ?
               cfg_snap : dat_snap;
  end

  // word_fired stays up from the 16th falling edge to the next frame's first
  always_ff @(negedge host_sclk or posedge rst) begin
    if (rst) begin
      word_fired <= 1'b0;
      rd_cfg_sel <= 1'b0;
      out_bit <= 1'b0;
    end else begin
      if (bit_cnt == CNT_FULL) begin
        word_fired <= 1'b1;
      end else if (bit_cnt != 5'h00) begin
        word_fired <= 1'b0;
      end
      if (bit_cnt == CNT_CMD) begin
        rd_cfg_sel <= (shift_in[1:0] == CMD_RD_CFG);
      end
      out_bit <= out_word[4'hf - bit_cnt[3:0]];
    end
  end

  // first bit shows from the select edge, the rest from falling edges
  assign host_dout = (bit_cnt == 5'h00) ? dat_snap[F_AVAIL] : out_bit;

  // ****************************************************
  // synchronisers into core_clk
  // ****************************************************
  logic cs_meta, cs_s;
  logic fired_meta, fired_s, fired_d;
  logic rx_meta, rx_s;
  logic cts_meta, cts_s;

  // pins and the sclk-domain level each pass two flops
  always_ff @(posedge core_clk) begin
    cs_meta <= host_cs_n;
    cs_s <= cs_meta;
    fired_meta <= word_fired;
    fired_s <= fired_meta;
    fired_d <= fired_s;
    rx_meta <= uart_rx;
    rx_s <= rx_meta;
    cts_meta <= cts_n;
    cts_s <= cts_meta;
  end

  // ****************************************************
  // configuration and word decode
  // ****************************************************
  logic [BAUD_W-1:0] baud_divisor_sel;
  logic fifo_disable_n;
  logic infrared_timing_sel;
  logic short_word_sel;
  logic extra_bit_enable;
  logic rx_avail_irq_mask;
  logic extra_bit_irq_mask;
  logic activity_frame_err_irq_mask;
  logic send_request;
  logic word_ok;
  logic [1:0] word_cmd;
  logic apply;
  logic pop_req;

  assign word_cmd = shift_in[CMD_HI:CMD_LO];
  // a completed word is acted on only once the host has deselected
  assign apply = word_ok && cs_s;
  assign pop_req = fired_s && !fired_d && !word_cmd[0];

  // completion flag: only a full sixteen-bit word ever raises it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_ok <= 1'b0;
    end else if (fired_s && !fired_d) begin
      word_ok <= 1'b1;
    end else if (apply) begin
      word_ok <= 1'b0;
    end
  end

  // config register, loaded from a write-config word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      baud_divisor_sel <= BAUD_RST;
      fifo_disable_n <= 1'b0;
      infrared_timing_sel <= 1'b0;
      short_word_sel <= 1'b0;
      extra_bit_enable <= 1'b0;
      rx_avail_irq_mask <= 1'b0;
      extra_bit_irq_mask <= 1'b0;
      activity_frame_err_irq_mask <= 1'b0;
    end else if (apply && word_cmd == CMD_WR_CFG) begin
      baud_divisor_sel <= shift_in[F_BAUD_HI:F_BAUD_LO];
      fifo_disable_n <= shift_in[F_FIFO_DIS];
      infrared_timing_sel <= shift_in[F_IR];
      short_word_sel <= shift_in[F_SHORT];
      extra_bit_enable <= shift_in[F_EXT_EN];
      rx_avail_irq_mask <= shift_in[F_RX_MASK];
      extra_bit_irq_mask <= shift_in[F_EXT_MASK];
      activity_frame_err_irq_mask <= shift_in[F_ACT_MASK];
    end
  end

  // ****************************************************
  // transmit path
  // ****************************************************
  ucs_ser_state_t tx_state;
  logic [DATA_W-1:0] tx_buf;
  logic tx_buf_extra;
  logic tx_pending;
  logic [DATA_W-1:0] tx_sh;
  logic tx_xbit;
  logic [3:0] tx_idx;
  logic [TIMER_W-1:0] tx_tmr;
  logic tx_bit;
  logic tx_end;
  logic [TIMER_W-1:0] period;
  logic [TIMER_W-1:0] ir_len;
  logic [3:0] last_idx;

  assign period = bit_period(baud_divisor_sel);
  assign ir_len = TIMER_W'((period * IR_PULSE_NUM) >> IR_PULSE_SHIFT);
  assign last_idx = short_word_sel ? 4'h6 : 4'h7;
  assign tx_end = (tx_tmr == period - TIMER_W'(1));

  // data word: rts always, character buffered until the shifter is free
  always_ff @(posedge core_clk) begin
    if (rst) begin
      send_request <= 1'b0;
      tx_pending <= 1'b0;
      tx_buf <= '0;
      tx_buf_extra <= 1'b0;
    end else begin
      if (apply && word_cmd == CMD_WR_DAT) begin
        send_request <= shift_in[F_RTS];
        tx_buf <= shift_in[DATA_W-1:0];
        tx_buf_extra <= shift_in[F_XBIT];
        tx_pending <= 1'b1;
      end else if (tx_state == UCS_IDLE) begin
        tx_pending <= 1'b0;
      end
    end
  end

  // transmit shifter; a new buffer is accepted only while idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_state <= UCS_IDLE;
      tx_tmr <= '0;
      tx_idx <= 4'h0;
      tx_sh <= '0;
      tx_xbit <= 1'b0;
    end else begin
      tx_tmr <= (tx_state == UCS_IDLE || tx_end) ? '0 : tx_tmr + TIMER_W'(1);
      unique case (tx_state)
        UCS_IDLE: begin
          if (tx_pending) begin
            tx_sh <= tx_buf;
            tx_xbit <= tx_buf_extra;
            tx_idx <= 4'h0;
            tx_state <= UCS_START;
          end
        end
        UCS_START: if (tx_end) tx_state <= UCS_DATA;
        UCS_DATA: begin
          if (tx_end) begin
            tx_sh <= tx_sh >> 1;
            tx_idx <= tx_idx + 4'h1;
            if (tx_idx == last_idx) begin
              tx_state <= extra_bit_enable ? UCS_EXTRA : UCS_STOP;
            end
          end
        end
        UCS_EXTRA: if (tx_end) tx_state <= UCS_STOP;
        UCS_STOP: if (tx_end) tx_state <= UCS_IDLE;
      endcase
    end
  end

  // current line level; short words never reach bit 7
  always_comb begin
    unique case (tx_state)
      UCS_START: tx_bit = 1'b0;
      UCS_DATA: tx_bit = tx_sh[0];
      UCS_EXTRA: tx_bit = tx_xbit;
      default: tx_bit = 1'b1;
    endcase
  end

  // infrared: a zero is a short high pulse, everything else low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      uart_tx <= 1'b1;
    end else if (infrared_timing_sel) begin
      uart_tx <= !tx_bit && (tx_tmr < ir_len);
    end else begin
      uart_tx <= tx_bit;
    end
  end

  // ****************************************************
  // receive path and fifo
  // ****************************************************
  ucs_ser_state_t rx_state;
  logic [TIMER_W-1:0] rx_tmr;
  logic [3:0] rx_idx;
  logic [DATA_W-1:0] rx_sh;
  logic rx_xbit;
  logic rx_tick;
  logic push;
  logic frame_err;
  logic [DATA_W:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr, rd_ptr;
  logic [PTR_W:0] fill;
  logic [PTR_W:0] cap;
  logic pop;
  logic rx_avail_flag;
  logic [DATA_W:0] head;

  // sampling starts half a bit into the start bit; receive is plain nrz only
  assign rx_tick = (rx_tmr == '0);
  assign cap = fifo_disable_n ? (PTR_W+1)'(1) : (PTR_W+1)'(FIFO_DEPTH);
  assign rx_avail_flag = (fill != '0);
  assign pop = pop_req && rx_avail_flag;
  assign push = (rx_state == UCS_STOP) && rx_tick && rx_s && (fill != cap || pop);
  assign head = rx_avail_flag ? fifo_mem[rd_ptr] : '0;

  // receive shifter; error state follows each stop bit, set beats the config clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_state <= UCS_IDLE;
      rx_tmr <= '0;
      rx_idx <= 4'h0;
      rx_sh <= '0;
      rx_xbit <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      rx_tmr <= rx_tick ? period - TIMER_W'(1) : rx_tmr - TIMER_W'(1);
      if (apply && word_cmd == CMD_WR_CFG) begin
        frame_err <= 1'b0;
      end
      unique case (rx_state)
        UCS_IDLE: begin
          rx_tmr <= period >> 1;
          if (!rx_s) rx_state <= UCS_START;
        end
        UCS_START: if (rx_tick) begin
          rx_state <= rx_s ? UCS_IDLE : UCS_DATA;
          rx_idx <= 4'h0;
          rx_sh <= '0;
        end
        UCS_DATA: if (rx_tick) begin
          rx_sh[rx_idx[2:0]] <= rx_s;
          rx_idx <= rx_idx + 4'h1;
          rx_xbit <= 1'b0;
          if (rx_idx == last_idx) begin
            rx_state <= extra_bit_enable ? UCS_EXTRA : UCS_STOP;
          end
        end
        UCS_EXTRA: if (rx_tick) begin
          rx_xbit <= rx_s;
          rx_state <= UCS_STOP;
        end
        UCS_STOP: if (rx_tick) begin
          frame_err <= !rx_s; // a clean stop clears it
          rx_state <= UCS_IDLE;
        end
      endcase
    end
  end

  // fifo storage: extra bit kept with its character, overrun drops the new one
  always_ff @(posedge core_clk) begin
    if (push) begin
      fifo_mem[wr_ptr] <= {rx_xbit, rx_sh};
    end
  end

  // pointers; with the fifo off only one entry is ever held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
      if (pop) rd_ptr <= (rd_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
      fill <= fill + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  // ****************************************************
  // read words, pins and interrupt
  // ****************************************************
  // snapshots only move while deselected, so the sclk side sees them stable
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_snap <= '0;
      dat_snap <= '0;
    end else if (cs_s) begin
      cfg_snap <= '0;
      cfg_snap[F_AVAIL] <= rx_avail_flag;
      cfg_snap[F_FIFO_DIS] <= fifo_disable_n;
      cfg_snap[F_RX_MASK] <= rx_avail_irq_mask;
      cfg_snap[F_EXT_MASK] <= extra_bit_irq_mask;
      cfg_snap[F_ACT_MASK] <= activity_frame_err_irq_mask;
      cfg_snap[F_IR] <= infrared_timing_sel;
      cfg_snap[F_SHORT] <= short_word_sel;
      cfg_snap[F_EXT_EN] <= extra_bit_enable;
      cfg_snap[F_BAUD_HI:F_BAUD_LO] <= baud_divisor_sel;
      dat_snap <= '0;
      dat_snap[F_AVAIL] <= rx_avail_flag;
      dat_snap[F_ERR] <= frame_err;
      dat_snap[F_PERMIT] <= !cts_s;
      dat_snap[F_XBIT] <= head[DATA_W] && extra_bit_enable;
      dat_snap[DATA_W-1:0] <= {head[DATA_W-1] && !short_word_sel, head[DATA_W-2:0]};
    end
  end

  // pin drivers; irq is an open-drain low, independent of select
  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_dout_oe_n <= 1'b1;
      rts_n <= 1'b1;
      irq_o <= 1'b0;
      irq_oe_n <= 1'b1;
    end else begin
      host_dout_oe_n <= cs_s;
      rts_n <= !send_request;
      irq_o <= 1'b0;
      irq_oe_n <= !((rx_avail_irq_mask && rx_avail_flag)
                  || (extra_bit_irq_mask && rx_avail_flag && head[DATA_W])
                  || (activity_frame_err_irq_mask && frame_err));
    end
  end

endmodule

// ### ucs_pkg.sv
// ucs_pkg: shared constants and state types for the serial-word uart control block.
// assumes one core clock at CLK_HZ; the host word layout below is fixed for both directions.
package ucs_pkg;
  // ****************************************************
  // host word layout
  // ****************************************************
  localparam int WORD_BITS = 16;
  localparam int CMD_HI = 15;
  localparam int CMD_LO = 14;
  localparam logic [1:0] CMD_RD_DAT = 2'h0;
  localparam logic [1:0] CMD_RD_CFG = 2'h1;
  localparam logic [1:0] CMD_WR_DAT = 2'h2;
  localparam logic [1:0] CMD_WR_CFG = 2'h3;
  localparam int F_AVAIL = 15;
  localparam int F_FIFO_DIS = 13;
  localparam int F_RX_MASK = 12;
  localparam int F_EXT_MASK = 11;
  localparam int F_ACT_MASK = 10;
  localparam int F_IR = 9;
  localparam int F_SHORT = 8;
  localparam int F_EXT_EN = 7;
  localparam int F_BAUD_HI = 3;
  localparam int F_BAUD_LO = 0;
  localparam int F_ERR = 10;
  localparam int F_PERMIT = 9;
  localparam int F_RTS = 9;
  localparam int F_XBIT = 8;
  localparam int DATA_W = 8;
  localparam int BAUD_W = 4;
  // ****************************************************
  // reset values and timing
  // ****************************************************
  localparam logic [3:0] BAUD_RST = 4'h0;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_HZ = 25000000;
  localparam int TOP_BAUD = 230400;
  localparam int BAUD_BASE_CYC = CLK_HZ / TOP_BAUD;
  localparam int TIMER_W = 12;
  localparam int IR_PULSE_NUM = 3;
  localparam int IR_PULSE_SHIFT = 4;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_CMD = 5'h02;
  // ****************************************************
  // state types
  // ****************************************************
  typedef enum logic [2:0] {UCS_IDLE, UCS_START, UCS_DATA, UCS_EXTRA, UCS_STOP} ucs_ser_state_t;
endpackage

// ### ucs_host_model.sv
// ucs_host_model: host end of the 16-bit serial word port, mode 0, msb first.
// assumes the bench calls xfer one word at a time; sclk moves only inside frames.
`timescale 1ns/1ps
module ucs_host_model (
  // host port pins
  output logic host_sclk,
  output logic host_cs_n,
  output logic host_din,
  input wire logic host_dout,
  input wire logic host_dout_oe_n
);
  // ****************************************************
  // word transfer
  // ****************************************************
  // idle pins: clock low, deselected
  initial begin
    host_sclk = 1'b0;
    host_cs_n = 1'b1;
    host_din = 1'b1;
  end
  // nbits below 16 raises cs_n early, so the word must be dropped
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    host_cs_n = 1'b0;
    #130;  // select settles 3+ core cycles first
    for (int i = 0; i < nbits; i++) begin
      host_din = word[15 - i];  // msb first
      #7.5;
      host_sclk = 1'b1;
      rd[15 - i] = host_dout;  // dout sampled on each rising edge, driven or not
      #7.5;
      host_sclk = 1'b0;
    end
    #10;
    host_cs_n = 1'b1;  // word acted on from here
    host_din = ~host_din;  // released line shows no stale bit
    #250;  // deselect gap over 5 core cycles
  endtask
endmodule

// ### ucs_ctrl_chk.sv
// ucs_ctrl_chk: port-level assertions for ucs_uart_ctrl.
// assumes core_clk and a synchronous active-high rst; bound from the foot of this file.
`timescale 1ns/1ps
module ucs_ctrl_chk #(
  parameter int FIFO_DEPTH = 8,
  parameter int BAUD_BASE = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // host port
  input wire logic host_sclk,
  input wire logic host_cs_n,
  input wire logic host_din,
  input wire logic host_dout,
  input wire logic host_dout_oe_n,
  // line, handshake and interrupt
  input wire logic uart_rx,
  input wire logic cts_n,
  input wire logic uart_tx,
  input wire logic rts_n,
  input wire logic irq_o,
  input wire logic irq_oe_n
);
  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_irq_pin_low: assert property (irq_o == 1'b0)
    else $error("irq data pin not low");
  chk_rst_idle: assert property ($fell(rst) |-> rts_n && irq_oe_n && uart_tx)
    else $error("outputs not idle after reset");
  // reset held over two edges must already show the idle pins
  chk_rst_hold: assert property (
    disable iff (1'b0) rst && $past(rst) |-> rts_n && irq_oe_n)
    else $error("reset did not clear rts or irq");
  chk_oe_on: assert property ($fell(host_cs_n) |-> ##[1:4] !host_dout_oe_n)
    else $error("dout not driven after select");
  chk_oe_off: assert property ($rose(host_cs_n) |-> ##[1:4] host_dout_oe_n)
    else $error("dout not released after deselect");
  chk_oe_idle: assert property (host_cs_n [*5] |-> host_dout_oe_n)
    else $error("dout driven while deselected");
  // effects wait for deselect, so rts cannot move inside a frame
  chk_rts_frame: assert property (!host_cs_n && !$past(host_cs_n) |-> $stable(rts_n))
    else $error("rts moved during a frame");
  chk_rts_late: assert property ($rose(host_cs_n) |-> $stable(rts_n) [*2])
    else $error("rts moved too early");
  // main scenarios reached
  cover property ($fell(rts_n));
  cover property ($fell(irq_oe_n));
  cover property ($fell(uart_tx));
  cover property ($rose(host_cs_n) ##[1:4] host_dout_oe_n);
endmodule
bind ucs_uart_ctrl ucs_ctrl_chk #(.FIFO_DEPTH(FIFO_DEPTH), .BAUD_BASE(BAUD_BASE)) chk (
  .core_clk(core_clk), .rst(rst), .host_sclk(host_sclk), .host_cs_n(host_cs_n),
  .host_din(host_din), .host_dout(host_dout), .host_dout_oe_n(host_dout_oe_n),
  .uart_rx(uart_rx), .cts_n(cts_n), .uart_tx(uart_tx), .rts_n(rts_n),
  .irq_o(irq_o), .irq_oe_n(irq_oe_n));

// ### tb.sv
// tb: self-checking bench for ucs_uart_ctrl with a host model and a line driver.
// assumes BAUD_BASE shortened to 4; irq line has a pull-up.
`timescale 1ns/1ps
module tb;
  import ucs_pkg::*;
  localparam int BB = 4;
  logic core_clk, rst, host_sclk, host_cs_n, host_din, host_dout, host_dout_oe_n;
  logic uart_rx, cts_n, uart_tx, rts_n, irq_o, irq_oe_n, irq_line, shrt, ext, x;
  logic [15:0] rd, w;
  logic [9:0] got;
  logic [7:0] d;
  logic [3:0] baud;
  int seed = 16550;
  int bitc, fail_count, compares;
  // ****************************************************
  // clock, pins, instances
  // ****************************************************
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;
  assign irq_line = irq_oe_n ? 1'b1 : irq_o;  // pull-up when released
  ucs_uart_ctrl #(.FIFO_DEPTH(8), .BAUD_BASE(BB)) dut (
    .core_clk(core_clk), .rst(rst), .host_sclk(host_sclk), .host_cs_n(host_cs_n),
    .host_din(host_din), .host_dout(host_dout), .host_dout_oe_n(host_dout_oe_n),
    .uart_rx(uart_rx), .cts_n(cts_n), .uart_tx(uart_tx), .rts_n(rts_n),
    .irq_o(irq_o), .irq_oe_n(irq_oe_n));
  ucs_host_model host (.host_sclk(host_sclk), .host_cs_n(host_cs_n), .host_din(host_din),
    .host_dout(host_dout), .host_dout_oe_n(host_dout_oe_n));
  // ****************************************************
  // compares and expectations
  // ****************************************************
  task automatic check_word(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
    compares++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("Error %0t: word got %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_bit(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t: bit got %b expected %b", $time, g, e);
    end
  endtask
  // readback keeps only the stored fields
  function automatic logic [15:0] exp_cfg(input logic [15:0] v, input logic av);
    return {av, 1'b0, v[13:7], 3'b000, v[3:0]};
  endfunction
  function automatic logic [15:0] exp_rx(input logic [7:0] v, input logic xb, input logic av);
    return {av, 6'h00, ext & xb, shrt ? {1'b0, v[6:0]} : v};
  endfunction
  // line bits after start, lsb first, stop last
  function automatic logic [9:0] exp_line(input logic [7:0] v, input logic xb);
    logic [9:0] r;
    int nd;
    nd = 8 - int'(shrt);
    r = 10'h000;
    for (int i = 0; i < nd; i++) r[i] = v[i];
    if (ext) r[nd] = xb;
    r[nd + int'(ext)] = 1'b1;
    return r;
  endfunction
  // ****************************************************
  // drivers
  // ****************************************************
  // write config with a random divisor, ir off
  task automatic set_mode(input logic fd, rm, xm, em, s, e);
    baud = 4'(1 + ($unsigned($random(seed)) % 3));
    shrt = s;
    ext = e;
    bitc = BB * (int'(baud) + 1);
    host.xfer({CMD_WR_CFG, fd, rm, xm, em, 1'b0, s, e, 3'b000, baud}, 16, rd);
  endtask
  task automatic drive_bit(input logic v);
    #2 uart_rx = v;
    repeat (bitc) @(posedge core_clk);
  endtask
  task automatic send_rx(input logic [7:0] v, input logic xb, input logic stp);
    @(posedge core_clk);
    drive_bit(1'b0);
    for (int i = 0; i < 8 - int'(shrt); i++) drive_bit(v[i]);
    if (ext) drive_bit(xb);
    drive_bit(stp);
    drive_bit(1'b1);
  endtask
  // sample mid-bit after the start edge
  task automatic get_tx(output logic [9:0] v);
    v = 10'h000;
    for (int k = 0; k < 4000 && uart_tx !== 1'b0; k++) @(posedge core_clk);
    check_bit(uart_tx, 1'b0);
    repeat (bitc / 2) @(posedge core_clk);
    for (int i = 0; i < 9 - int'(shrt) + int'(ext); i++) begin
      repeat (bitc) @(posedge core_clk);
      v[i] = uart_tx;
    end
  endtask
  task automatic rd_data(input logic [7:0] v, input logic xb, input logic av);
    host.xfer({CMD_RD_DAT, 14'h0000}, 16, rd);
    check_word(rd, exp_rx(v, xb, av), 16'h81ff);
  endtask
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  initial begin
    rst = 1'b1;
    uart_rx = 1'b1;
    cts_n = 1'b0;
    shrt = 1'b0;
    ext = 1'b0;
    repeat (20) @(posedge core_clk);
    #2 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    check_bit(rts_n, 1'b1);
    host.xfer({CMD_RD_CFG, 14'h0000}, 16, rd);
    check_word(rd, 16'h0000, 16'hffff);
    // random configs, each followed by an aborted rewrite
    for (int i = 0; i < 6; i++) begin
      w = {CMD_WR_CFG, 14'($random(seed))};
      host.xfer(w, 16, rd);
      host.xfer(~w | 16'hc000, 4 + i * 2, rd);
      host.xfer({CMD_RD_CFG, 14'h0000}, 16, rd);
      check_word(rd, exp_cfg(w, 1'b0), 16'hffff);
      check_bit(uart_tx, ~w[F_IR]);
    end
    // clear-to-send, with a mid-run reset that must not touch it
    for (int c = 0; c < 3; c++) begin
      @(posedge core_clk) #2 cts_n = (c == 2) ? 1'b1 : 1'($random(seed));
      rst = (c == 2);
      repeat (4) @(posedge core_clk);
      #2 rst = 1'b0;
      repeat (4) @(posedge core_clk);
      host.xfer({CMD_RD_DAT, 14'h0000}, 16, rd);
      check_bit(rd[F_PERMIT], ~cts_n);
    end
    // every word length: send, then receive with the avail interrupt
    for (int m = 0; m < 4; m++) begin
      set_mode(1'b0, 1'b1, 1'b0, 1'b0, m[0], m[1]);
      d = 8'($random(seed));
      d[7] = ~m[0];
      x = 1'($random(seed));
      fork
        host.xfer({CMD_WR_DAT, 4'h0, m[0], x, d}, 16, rd);
        get_tx(got);
      join
      check_word({6'h00, got}, {6'h00, exp_line(d, x)}, 16'h03ff);
      check_bit(rts_n, ~m[0]);
      send_rx(~d, ~x, 1'b1);
      repeat (4) @(posedge core_clk);
      check_bit(irq_line, 1'b0);
      rd_data(~d, ~x, 1'b1);
      check_bit(irq_line, 1'b1);
    end
    // extra-bit interrupt follows the received extra bit
    set_mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    for (int k = 1; k >= 0; k--) begin
      send_rx(d, k[0], 1'b1);
      repeat (4) @(posedge core_clk);
      check_bit(irq_line, ~k[0]);
      rd_data(d, k[0], 1'b1);
    end
    // framing error raises its interrupt until a config write
    set_mode(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    send_rx(d, 1'b0, 1'b0);
    repeat (4) @(posedge core_clk);
    check_bit(irq_line, 1'b0);
    host.xfer({CMD_RD_DAT, 14'h0000}, 16, rd);
    check_bit(rd[F_ERR], 1'b1);
    set_mode(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    check_bit(irq_line, 1'b1);
    // fifo keeps three, single holding register keeps the first
    for (int f = 0; f < 2; f++) begin
      set_mode(f[0], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 3; i++) send_rx(d + 8'(i * 17), 1'b0, 1'b1);
      for (int i = 0; i < 3 - 2 * f; i++) rd_data(d + 8'(i * 17), 1'b0, 1'b1);
      host.xfer({CMD_RD_CFG, 14'h0000}, 16, rd);
      check_bit(rd[F_AVAIL], 1'b0);
    end
    print_verdict();
  end
  // hang guard, far beyond the expected run
  initial begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    $display("Error %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
